//--- design/smsc_pkg.sv
// Package for the spindle motor servo controller: register map, fields, modes and timing.
package smsc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'h04;     // Register 1: operating mode and anti-wind-up.
    localparam logic [7:0] ADDR_GAIN = 8'h10;     // Register 4: gain and crossovers.
    localparam logic [7:0] ADDR_OUTC = 8'h18;     // Register 6: output mode and power limit.
    localparam logic [7:0] ADDR_VIAC = 8'h34;     // Versatile pin control 1101.
    localparam logic [7:0] ADDR_BRAK = 8'h38;     // Register E: brake threshold select.
    localparam logic [7:0] ADDR_STAT = 8'h40;     // Status: mode, flags, integrator.
    localparam logic [7:0] ADDR_SPEED = 8'h44;    // Status: measured speed and fill.

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int MODE_LSB = 0;
    localparam int AWU_BIT = 3;
    localparam int GAIN_LSB = 0;
    localparam int F4_LSB = 3;
    localparam int F3_LSB = 5;
    localparam int OMODE_LSB = 0;
    localparam int PLIM_LSB = 2;
    localparam logic [3:0] VIA_FOUR_LINE = 4'h0;
    localparam logic [3:0] VIA_RESET = 4'hF;

    // ------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SMSC_OFF, SMSC_START1, SMSC_START2, SMSC_JUMP, SMSC_JUMP1, SMSC_PLAY, SMSC_STOP1, SMSC_STOP2
    } smsc_mode_t;

    typedef enum logic [1:0] {
        SMSC_OUT_PDM, SMSC_OUT_PWM2, SMSC_OUT_PWM4, SMSC_OUT_DENS
    } smsc_omode_t;

    // Motor pin bundle.
    typedef struct packed {
        logic a;
        logic b;
        logic four;
        logic five;
    } smsc_motor_t;

    // ------------------------------------------------------------
    // Buffer, speed and timing
    // ------------------------------------------------------------
    localparam int FIFO_SPAN = 20;                 // Frames covered by the density-mode duty.
    localparam int FIFO_HALF = 8;                  // Half-full fill, giving 60 percent duty.
    localparam int FIFO_DUTY_OFS = 4;              // Fill plus this is the duty in twentieths.
    localparam int SPEED_NOM = 256;
    localparam int SPEED_START_PCT = 75;
    localparam int SPEED_STOP_PCT_HI = 12;
    localparam int SPEED_STOP_PCT_LO = 6;
    localparam int CLK_HZ = 50_000_000;
    localparam int PWM4_HZ = 22_050;
    localparam int DENS_HZ = 300;
    localparam int PDM_KHZ = 4_230;
    localparam int PWM4_CYC = CLK_HZ / PWM4_HZ;
    localparam int DENS_CYC = CLK_HZ / DENS_HZ;
    localparam logic [15:0] PDM_STEP = 16'(PDM_KHZ * 65536 / (CLK_HZ / 1000));

endpackage : smsc_pkg

//--- design/smsc_servo.sv
// Spindle motor servo controller with APB register access.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
module smsc_servo #(
    parameter int DENS_PERIOD = smsc_pkg::DENS_CYC
) (
    input wire logic pclk, // System clock.
    input wire logic presetn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [7:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic [4:0] fifo_fill, // Buffer fill, frames, 0..19.
    input wire logic fifo_overflow, // Buffer overflow pulse.
    input wire logic [9:0] pll_speed, // Recovered speed, 256 is nominal.
    output logic motor_out_a, // Motor line a.
    output logic motor_out_b, // Motor line b.
    output logic versatile_pin_four, // Motor line c in four-line mode.
    output logic versatile_pin_five, // Motor line d in four-line mode.
    output logic motor_stopped_flag, // Disc stopped.
    output logic pll_reset, // Holds the PLL in reset.
    output logic fifo_reset, // Forces the buffer to half full.
    output logic audio_mute, // Mutes audio.
    output logic conceal // Asks for interpolation after overflow.
);
    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic [3:0] mode_reg_q;
    logic [6:0] gain_q;
    logic [3:0] outc_q;
    logic [3:0] via_q;
    logic brake_q;
    smsc_pkg::smsc_mode_t mode_q, mode_d;
    logic stopped_q;
    logic signed [15:0] integ_q, integ_d;
    logic [9:0] spd_q1, spd_q2, spd_q3, spd;
    logic [4:0] fill_q1, fill_q2, fill_q3, fill;
    logic ovf_q1, ovf_q2, ovf_q3, ovf_prev_q;
    logic [31:0] rdata_d;

    wire wr_en = psel & penable & pwrite;
    wire rd_phase = psel & ~penable;
    wire hit_mode = paddr == smsc_pkg::ADDR_MODE;
    wire hit_gain = paddr == smsc_pkg::ADDR_GAIN;
    wire hit_outc = paddr == smsc_pkg::ADDR_OUTC;
    wire hit_via = paddr == smsc_pkg::ADDR_VIAC;
    wire hit_brak = paddr == smsc_pkg::ADDR_BRAK;
    wire hit_stat = paddr == smsc_pkg::ADDR_STAT;
    wire hit_spd = paddr == smsc_pkg::ADDR_SPEED;
    wire mapped = hit_mode | hit_gain | hit_outc | hit_via | hit_brak | hit_stat | hit_spd;
    // A mode write counts at the same edge as every other register write.
    wire mode_wr = wr_en & pready & hit_mode;
    wire [2:0] mode_wdata = pwdata[smsc_pkg::MODE_LSB +: 3];

    always_comb begin
        rdata_d = 32'h0;
        if (hit_mode) rdata_d = {28'h0, mode_reg_q};
        if (hit_gain) rdata_d = {25'h0, gain_q};
        if (hit_outc) rdata_d = {28'h0, outc_q};
        if (hit_via) rdata_d = {28'h0, via_q};
        if (hit_brak) rdata_d = {31'h0, brake_q};
        if (hit_stat) rdata_d = {integ_q, 12'h0, stopped_q, 3'(mode_q)};
        if (hit_spd) rdata_d = {11'h0, fill, 6'h0, spd};
    end

    // Ready rises in the access cycle, so every transfer takes exactly two cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= rd_phase;
            pslverr <= rd_phase & ~mapped;
            prdata <= (rd_phase & ~pwrite) ? rdata_d : 32'h0;
        end
    end

    // Writes land when pready is high in the access cycle.
    wire wr_take = wr_en & pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain_q <= 7'h0;
            outc_q <= 4'h0;
            via_q <= smsc_pkg::VIA_RESET;
            brake_q <= 1'b0;
            mode_reg_q <= 4'h0;
        end else begin
            if (wr_take & hit_gain) gain_q <= pwdata[6:0];
            if (wr_take & hit_outc) outc_q <= pwdata[3:0];
            if (wr_take & hit_via) via_q <= pwdata[3:0];
            if (wr_take & hit_brak) brake_q <= pwdata[0];
            if (wr_take & hit_mode) mode_reg_q <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spd_q1 <= 10'h0; spd_q2 <= 10'h0; spd_q3 <= 10'h0; spd <= 10'h0;
            fill_q1 <= 5'h0; fill_q2 <= 5'h0; fill_q3 <= 5'h0; fill <= 5'h0;
            ovf_q1 <= 1'b0; ovf_q2 <= 1'b0; ovf_q3 <= 1'b0; ovf_prev_q <= 1'b0;
        end else begin
            spd_q1 <= pll_speed; spd_q2 <= spd_q1; spd_q3 <= spd_q2;
            fill_q1 <= fifo_fill; fill_q2 <= fill_q1; fill_q3 <= fill_q2;
            ovf_q1 <= fifo_overflow; ovf_q2 <= ovf_q1; ovf_q3 <= ovf_q2;
            if (spd_q2 == spd_q3) spd <= spd_q3;
            if (fill_q2 == fill_q3) fill <= fill_q3;
            if (ovf_q2 == ovf_q3) ovf_prev_q <= ovf_q3;
        end
    end
    wire ovf_rise = (ovf_q2 == ovf_q3) & ovf_q3 & ~ovf_prev_q;

    // ------------------------------------------------------------
    // Mode machine
    // ------------------------------------------------------------
    localparam logic [9:0] SPD_START = 10'(smsc_pkg::SPEED_NOM * smsc_pkg::SPEED_START_PCT / 100);
    localparam logic [9:0] SPD_STOP_HI = 10'(smsc_pkg::SPEED_NOM * smsc_pkg::SPEED_STOP_PCT_HI / 100);
    localparam logic [9:0] SPD_STOP_LO = 10'(smsc_pkg::SPEED_NOM * smsc_pkg::SPEED_STOP_PCT_LO / 100);
    wire [9:0] stop_thr = brake_q ? SPD_STOP_LO : SPD_STOP_HI;
    wire dens_mode = smsc_pkg::smsc_omode_t'(outc_q[1:0]) == smsc_pkg::SMSC_OUT_DENS;

    always_comb begin
        mode_d = mode_q;
        if (mode_wr) begin
            mode_d = smsc_pkg::smsc_mode_t'(mode_wdata);
        end else begin
            case (mode_q)
                smsc_pkg::SMSC_START2: if (spd >= SPD_START) mode_d = smsc_pkg::SMSC_JUMP;
                smsc_pkg::SMSC_STOP2: if (spd <= stop_thr) mode_d = smsc_pkg::SMSC_OFF;
                default: mode_d = mode_q;
            endcase
        end
    end

    logic play_entry_q;
    logic conceal_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= smsc_pkg::SMSC_OFF;
            stopped_q <= 1'b0;
            play_entry_q <= 1'b0;
            conceal_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            if (mode_q == smsc_pkg::SMSC_STOP2 && mode_d == smsc_pkg::SMSC_OFF) stopped_q <= 1'b1;
            else if (mode_d != smsc_pkg::SMSC_OFF) stopped_q <= 1'b0;
            play_entry_q <= mode_d == smsc_pkg::SMSC_PLAY && mode_q != smsc_pkg::SMSC_PLAY;
            conceal_q <= mode_q == smsc_pkg::SMSC_PLAY && ovf_rise;
        end
    end

    // ------------------------------------------------------------
    // Servo loop
    // ------------------------------------------------------------
    // Gain steps of 3.2,4,6.4,8,12.8,16,25.6,32 in eighths of 3.2.
    logic [7:0] gain_mul;
    always_comb begin
        case (gain_q[2:0])
            3'h0: gain_mul = 8'h08;
            3'h1: gain_mul = 8'h0A;
            3'h2: gain_mul = 8'h10;
            3'h3: gain_mul = 8'h14;
            3'h4: gain_mul = 8'h20;
            3'h5: gain_mul = 8'h28;
            3'h6: gain_mul = 8'h40;
            default: gain_mul = 8'h50;
        endcase
    end
    // Crossovers map to integrator shifts; larger crossover means faster integration, except f3 settings 0 and 1, which share one shift.
    wire [3:0] f4_shift = 4'(4'h9 - {2'h0, gain_q[4:3]});
    wire [3:0] f3_shift = (gain_q[6:5] == 2'h0) ? 4'h4 : 4'(4'h5 - {2'h0, gain_q[6:5]});

    wire signed [7:0] err = 8'(signed'({3'h0, fill}) - 8'sd8);
    wire signed [17:0] prop = 18'(err * signed'({1'b0, gain_mul}));
    wire signed [17:0] ctrl = 18'(prop + (integ_q >>> f3_shift));
    wire sat_pos = ctrl > 18'sd255;
    wire sat_neg = ctrl < -18'sd255;
    wire signed [8:0] servo_out = sat_pos ? 9'sd255 : sat_neg ? -9'sd255 : 9'(ctrl);
    wire awu = mode_reg_q[smsc_pkg::AWU_BIT];

    always_comb begin
        integ_d = integ_q;
        if (mode_q == smsc_pkg::SMSC_JUMP1) integ_d = 16'sh0;
        else if (mode_q == smsc_pkg::SMSC_JUMP) integ_d = integ_q;
        else if (mode_q == smsc_pkg::SMSC_PLAY && !(awu && (sat_pos || sat_neg)))
            integ_d = 16'(integ_q + (16'(err) <<< (4'hF - f4_shift)));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) integ_q <= 16'sh0;
        else integ_q <= dens_mode ? integ_q : integ_d;
    end

    // Power limit: full, three quarters, half, 37 percent (95 of 255).
    logic [7:0] fixed_lvl;
    always_comb begin
        case (outc_q[3:2])
            2'h0: fixed_lvl = 8'hFF;
            2'h1: fixed_lvl = 8'hBF;
            2'h2: fixed_lvl = 8'h80;
            default: fixed_lvl = 8'h5F;
        endcase
    end

    logic signed [8:0] drive;
    always_comb begin
        case (mode_q)
            smsc_pkg::SMSC_START1, smsc_pkg::SMSC_START2: drive = signed'({1'b0, fixed_lvl});
            smsc_pkg::SMSC_STOP1, smsc_pkg::SMSC_STOP2: drive = -signed'({1'b0, fixed_lvl});
            smsc_pkg::SMSC_JUMP, smsc_pkg::SMSC_JUMP1, smsc_pkg::SMSC_PLAY: drive = servo_out;
            default: drive = 9'sd0;
        endcase
    end
    wire [7:0] mag = drive[8] ? 8'(-drive) : drive[7:0];

    // ------------------------------------------------------------
    // Modulators
    // ------------------------------------------------------------
    logic [11:0] pwm_cnt_q;
    logic [19:0] dens_cnt_q;
    logic [16:0] pdm_acc_q;
    wire [11:0] pwm_thr = 12'((32'(mag) * smsc_pkg::PWM4_CYC) / 255);
    wire [19:0] dens_thr = 20'((32'({27'h0, fill} + 32'(smsc_pkg::FIFO_DUTY_OFS)) * DENS_PERIOD)
                              / smsc_pkg::FIFO_SPAN);
    wire pwm_on = pwm_cnt_q < pwm_thr;
    // Widened before the product, or the nominal speed step would overflow and slow the carrier.
    wire [16:0] pdm_add = 17'((27'(spd) * smsc_pkg::PDM_STEP) >> 8);
    wire four_line = outc_q[1:0] == 2'(smsc_pkg::SMSC_OUT_PWM4) && via_q == smsc_pkg::VIA_FOUR_LINE;

    smsc_pkg::smsc_motor_t mot_d;
    always_comb begin
        mot_d = '0;
        case (smsc_pkg::smsc_omode_t'(outc_q[1:0]))
            smsc_pkg::SMSC_OUT_DENS: begin
                mot_d.a = dens_cnt_q < dens_thr;
                mot_d.b = pdm_acc_q[16];
            end
            smsc_pkg::SMSC_OUT_PWM2, smsc_pkg::SMSC_OUT_PWM4: begin
                mot_d.a = pwm_on & ~drive[8];
                mot_d.b = pwm_on & drive[8];
                mot_d.four = four_line & pwm_on & drive[8];
                mot_d.five = four_line & pwm_on & ~drive[8];
            end
            default: begin
                mot_d.a = pwm_on ^ drive[8];
                mot_d.b = ~(pwm_on ^ drive[8]);
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_cnt_q <= 12'h0;
            dens_cnt_q <= 20'h0;
            pdm_acc_q <= 17'h0;
            {motor_out_a, motor_out_b, versatile_pin_four, versatile_pin_five} <= 4'h0;
            motor_stopped_flag <= 1'b0;
            pll_reset <= 1'b1;
            fifo_reset <= 1'b1;
            audio_mute <= 1'b1;
            conceal <= 1'b0;
        end else begin
            pwm_cnt_q <= (pwm_cnt_q == 12'(smsc_pkg::PWM4_CYC - 1)) ? 12'h0 : 12'(pwm_cnt_q + 12'h1);
            dens_cnt_q <= (dens_cnt_q == 20'(DENS_PERIOD - 1)) ? 20'h0 : 20'(dens_cnt_q + 20'h1);
            pdm_acc_q <= 17'({1'b0, pdm_acc_q[15:0]} + pdm_add);
            {motor_out_a, motor_out_b, versatile_pin_four, versatile_pin_five} <= mot_d;
            motor_stopped_flag <= stopped_q;
            pll_reset <= mode_q == smsc_pkg::SMSC_START1;
            fifo_reset <= mode_q == smsc_pkg::SMSC_JUMP || mode_q == smsc_pkg::SMSC_JUMP1
                          || play_entry_q || conceal_q;
            audio_mute <= mode_q != smsc_pkg::SMSC_PLAY;
            conceal <= conceal_q;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_start2_jump;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == smsc_pkg::SMSC_START2 && !mode_wr && spd >= SPD_START) |=> mode_q == smsc_pkg::SMSC_JUMP;
    endproperty
    a_start2_jump: assert property (p_start2_jump) else $error("start2 did not go to jump");
    property p_stop2_off;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == smsc_pkg::SMSC_STOP2 && !mode_wr && spd <= stop_thr) |=> ##1 motor_stopped_flag;
    endproperty
    a_stop2_off: assert property (p_stop2_off) else $error("stop2 did not raise stopped flag");
    property p_mode_write;
        @(posedge pclk) disable iff (!presetn)
        mode_wr |=> mode_q == smsc_pkg::smsc_mode_t'($past(mode_wdata));
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write not applied");
    property p_jump1_zero;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == smsc_pkg::SMSC_JUMP1 && !dens_mode) |=> integ_q == 16'sh0;
    endproperty
    a_jump1_zero: assert property (p_jump1_zero) else $error("jump1 integrator not zero");
    property p_jump_hold;
        @(posedge pclk) disable iff (!presetn)
        mode_q == smsc_pkg::SMSC_JUMP |=> $stable(integ_q) && fifo_reset && audio_mute;
    endproperty
    a_jump_hold: assert property (p_jump_hold) else $error("jump did not hold and mute");
    property p_awu;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == smsc_pkg::SMSC_PLAY && awu && (sat_pos || sat_neg)) |=> $stable(integ_q);
    endproperty
    a_awu: assert property (p_awu) else $error("integrator moved while saturated");
    property p_dens_freeze;
        @(posedge pclk) disable iff (!presetn)
        dens_mode |=> $stable(integ_q);
    endproperty
    a_dens_freeze: assert property (p_dens_freeze) else $error("servo ran in density mode");
    property p_four_gate;
        @(posedge pclk) disable iff (!presetn)
        !four_line |=> !versatile_pin_four && !versatile_pin_five;
    endproperty
    a_four_gate: assert property (p_four_gate) else $error("pins four and five driven outside four-line mode");
    property p_start1_pll;
        @(posedge pclk) disable iff (!presetn)
        mode_q == smsc_pkg::SMSC_START1 |=> pll_reset;
    endproperty
    a_start1_pll: assert property (p_start1_pll) else $error("pll not reset in start1");
    property p_play_entry;
        @(posedge pclk) disable iff (!presetn)
        (mode_d == smsc_pkg::SMSC_PLAY && mode_q != smsc_pkg::SMSC_PLAY) |=> ##1 fifo_reset;
    endproperty
    a_play_entry: assert property (p_play_entry) else $error("play entry did not reset buffer");
    property p_overflow;
        @(posedge pclk) disable iff (!presetn)
        (mode_q == smsc_pkg::SMSC_PLAY && ovf_rise) |=> ##1 conceal && fifo_reset;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not recovered");

    c_start2: cover property (@(posedge pclk) disable iff (!presetn)
        mode_q == smsc_pkg::SMSC_START2 ##1 mode_q == smsc_pkg::SMSC_JUMP);
    c_stop2: cover property (@(posedge pclk) disable iff (!presetn) $rose(motor_stopped_flag));
    c_ovf: cover property (@(posedge pclk) disable iff (!presetn) $rose(conceal));
    c_four: cover property (@(posedge pclk) disable iff (!presetn) versatile_pin_four);
    c_awu: cover property (@(posedge pclk) disable iff (!presetn)
        mode_q == smsc_pkg::SMSC_PLAY && awu && sat_neg);

endmodule : smsc_servo

//--- tb/smsc_bridge_model.sv
// Motor bridge model that integrates the on-time of each motor line.
`timescale 1ns/1ps
module smsc_bridge_model (
    input wire logic pclk, // Sampling clock.
    input wire logic clr, // Clears the counters.
    input wire smsc_pkg::smsc_motor_t lines, // Lines from the controller.
    output logic [31:0] on_a, // Cycles line a was high.
    output logic [31:0] on_b, // Cycles line b was high.
    output logic [31:0] on_c, // Cycles pin four was high.
    output logic [31:0] on_d // Cycles pin five was high.
);
    // An unknown line turns its counter unknown, so a floating drive cannot pass.
    always @(posedge pclk) begin
        if (clr) begin
            on_a <= 32'h0;
            on_b <= 32'h0;
            on_c <= 32'h0;
            on_d <= 32'h0;
        end else begin
            on_a <= on_a + {31'h0, lines.a};
            on_b <= on_b + {31'h0, lines.b};
            on_c <= on_c + {31'h0, lines.four};
            on_d <= on_d + {31'h0, lines.five};
        end
    end
endmodule : smsc_bridge_model

//--- tb/smsc_servo_tb.sv
// Self-checking testbench for the spindle motor servo controller.
`timescale 1ns/1ps
module smsc_servo_tb;
    localparam int DENS_P = 200;
    localparam int PW = smsc_pkg::PWM4_CYC;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [4:0] fifo_fill = 5'h08;
    logic fifo_overflow = 1'b0;
    logic [9:0] pll_speed = 10'h000;
    logic clr = 1'b1;
    logic [31:0] prdata, on_a, on_b, on_c, on_d, rd, snap_c, snap_f;
    logic [31:0] n_conceal = 32'h0;
    logic [31:0] n_fres = 32'h0;
    logic pready, pslverr, err, motor_out_a, motor_out_b, versatile_pin_four, versatile_pin_five;
    logic motor_stopped_flag, pll_reset, fifo_reset, audio_mute, conceal;
    int fails = 0;
    int tests_run = 0;
    int pct[4] = '{100, 75, 50, 37};
    always #10 pclk = ~pclk;
    always @(posedge pclk) begin
        n_conceal <= n_conceal + {31'h0, conceal};
        n_fres <= n_fres + {31'h0, fifo_reset};
    end
    smsc_servo #(.DENS_PERIOD(DENS_P)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fifo_fill(fifo_fill), .fifo_overflow(fifo_overflow), .pll_speed(pll_speed), .motor_out_a(motor_out_a),
        .motor_out_b(motor_out_b), .versatile_pin_four(versatile_pin_four), .versatile_pin_five(versatile_pin_five),
        .motor_stopped_flag(motor_stopped_flag), .pll_reset(pll_reset), .fifo_reset(fifo_reset),
        .audio_mute(audio_mute), .conceal(conceal));
    smsc_bridge_model bridge (.pclk(pclk), .clr(clr),
        .lines({motor_out_a, motor_out_b, versatile_pin_four, versatile_pin_five}),
        .on_a(on_a), .on_b(on_b), .on_c(on_c), .on_d(on_d));
    // ----------------------------------------
    // Compare, bus and measurement tasks
    // ----------------------------------------
    task automatic summarize;
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic near(input string name, input int exp, input logic [31:0] got, input int tol);
        tests_run++;
        if ((^got === 1'bx) || (int'(got) > exp + tol) || (int'(got) < exp - tol)) begin
            fails++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask : near
    // Ends one idle edge after the access so the next setup never lands in the same step.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            summarize();
        end
        @(posedge pclk);
    endtask : apb
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, exp, rd);
    endtask : rdchk
    task automatic wait_mode(input logic [2:0] m);
        int n;
        n = 0;
        do begin
            apb(1'b0, smsc_pkg::ADDR_STAT, 32'h0);
            n++;
        end while (rd[2:0] !== m && n < 60);
        check("status mode", {29'h0, m}, {29'h0, rd[2:0]});
    endtask : wait_mode
    task automatic measure(input int n);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge pclk);
    endtask : measure
    initial begin
        repeat (100000) @(posedge pclk);
        fails++;
        summarize();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        check("reset outputs", 32'h7, {29'h0, pll_reset, fifo_reset, audio_mute});
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("via reset", smsc_pkg::ADDR_VIAC, {28'h0, smsc_pkg::VIA_RESET});
        rdchk("status reset", smsc_pkg::ADDR_STAT, 32'h0);
        apb(1'b0, 8'hFC, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        check("unmapped data", 32'h0, rd);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, smsc_pkg::ADDR_GAIN, 32'(i | ((i % 4) << 3) | ((i % 3) << 5)));
            rdchk("gain", smsc_pkg::ADDR_GAIN, 32'(i | ((i % 4) << 3) | ((i % 3) << 5)));
        end
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h1);
        wait_mode(3'h1);
        check("start1 pll reset", 32'h1, {31'h0, pll_reset});
        pll_speed <= 10'h0C8;
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h2);
        wait_mode(3'h3);
        check("jump reset and mute", 32'h3, {30'h0, fifo_reset, audio_mute});
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h4);
        wait_mode(3'h4);
        check("jump1 integrator", 32'h0, {16'h0, rd[31:16]});
        check("jump1 reset and mute", 32'h3, {30'h0, fifo_reset, audio_mute});
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h5);
        wait_mode(3'h5);
        check("play reset and mute", 32'h0, {30'h0, fifo_reset, audio_mute});
        snap_c = n_conceal;
        snap_f = n_fres;
        fifo_overflow <= 1'b1;
        repeat (12) @(posedge pclk);
        fifo_overflow <= 1'b0;
        check("overflow conceal", snap_c + 1, n_conceal);
        check("overflow buffer reset", snap_f + 1, n_fres);
        for (int t = 0; t < 2; t++) begin
            apb(1'b1, smsc_pkg::ADDR_BRAK, 32'(t));
            pll_speed <= 10'h0C8;
            apb(1'b1, smsc_pkg::ADDR_MODE, 32'h7);
            pll_speed <= (t == 0) ? 10'd31 : 10'd16;
            repeat (10) @(posedge pclk);
            wait_mode(3'h7);
            check("not yet stopped", 32'h0, {31'h0, motor_stopped_flag});
            pll_speed <= (t == 0) ? 10'd29 : 10'd14;
            wait_mode(3'h0);
            repeat (2) @(posedge pclk);
            check("stopped flag", 32'h1, {31'h0, motor_stopped_flag});
        end
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h5);
        pll_speed <= 10'h100;
        apb(1'b1, smsc_pkg::ADDR_OUTC, 32'h3);
        repeat (DENS_P + 8) @(posedge pclk);
        measure(DENS_P);
        near("density duty half", DENS_P * 12 / 20, on_a, 2);
        near("density speed pulse rate", DENS_P * 423 / 5000, on_b, 2);
        fifo_fill <= 5'h00;
        repeat (2 * DENS_P) @(posedge pclk);
        measure(DENS_P);
        near("density duty empty", DENS_P * 4 / 20, on_a, 2);
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h1);
        apb(1'b1, smsc_pkg::ADDR_VIAC, {28'h0, smsc_pkg::VIA_FOUR_LINE});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, smsc_pkg::ADDR_OUTC, 32'((i << 2) | 2));
            repeat (PW) @(posedge pclk);
            measure(PW);
            near("four-line accelerate", pct[i] * PW / 100, on_d, PW / 40);
            check("four-line no brake", 32'h0, on_c);
        end
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'h6);
        repeat (PW) @(posedge pclk);
        measure(PW);
        near("four-line brake", pct[3] * PW / 100, on_c, PW / 40);
        check("four-line no accelerate", 32'h0, on_d);
        apb(1'b1, smsc_pkg::ADDR_OUTC, 32'hD);
        repeat (PW) @(posedge pclk);
        measure(PW);
        near("two-line brake", pct[3] * PW / 100, on_b, PW / 40);
        check("two-line pins four and five idle", 32'h0, on_c | on_d);
        apb(1'b1, smsc_pkg::ADDR_MODE, 32'hD);
        repeat (10) @(posedge pclk);
        rdchk("anti-wind-up integrator hold", smsc_pkg::ADDR_STAT, 32'h5);
        summarize();
    end
endmodule : smsc_servo_tb
